//--- testbench/mcreg_core_model.sv
`timescale 1ns/1ps
module mcreg_core_model (
	// Clock
	input wire logic clk,
	// Register bus toward the block
	output logic sfr_wr,
	output logic sfr_rd,
	output logic [7:0] sfr_addr,
	output logic [7:0] sfr_wdata,
	// Answer from the block
	input wire logic [7:0] sfr_rdata,
	input wire logic sfr_hit
);
	initial begin
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		sfr_addr = 8'h00;
		sfr_wdata = 8'h00;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		sfr_wr = 1'b1;
		sfr_addr = a;
		sfr_wdata = d;
		@(posedge clk);
		#1;
		sfr_wr = 1'b0;
		// Stale data must not look valid after the strobe
		sfr_wdata = ~d;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d,
		output logic h);
		@(posedge clk);
		#1;
		sfr_rd = 1'b1;
		sfr_addr = a;
		@(posedge clk);
		#1;
		sfr_rd = 1'b0;
		d = sfr_rdata;
		h = sfr_hit;
	endtask : rd
endmodule : mcreg_core_model

//--- testbench/mcreg_monitor.sv
`timescale 1ns/1ps
module mcreg_monitor (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register bus
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata,
	input wire logic sfr_hit,
	// Decode
	input wire logic [7:0] data_addr,
	input wire logic data_indirect,
	input wire logic [2:0] data_region,
	// Program memory and power levels
	input wire logic xmove_wr,
	input wire logic code_rd,
	input wire logic flash_erase_req,
	input wire logic flash_wr,
	input wire logic flash_erase,
	input wire logic flash_blocked,
	input wire logic code_rd_en,
	input wire logic stop_enable,
	input wire logic program_write_enable
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence power_config_wr;
		sfr_wr && sfr_addr == mcreg_pkg::ADDR_POWER_CONFIG;
	endsequence
	sequence hole_rd;
		sfr_rd && sfr_addr == 8'h88;
	endsequence
	mapped_hit_a: assert property (sfr_rd && sfr_addr == 8'h87 |=> sfr_hit)
		else $error("mapped read without hit");
	hole_read_a: assert property (hole_rd |=> !sfr_hit && sfr_rdata == 0)
		else $error("unmapped read answered");
	pwe_level_a: assert property (power_config_wr |=>
		program_write_enable == $past(sfr_wdata[4]))
		else $error("write enable level wrong");
	stop_level_a: assert property (power_config_wr |=>
		stop_enable == $past(sfr_wdata[1]))
		else $error("stop enable level wrong");
	write_gate_a: assert property (xmove_wr && !program_write_enable
		&& !flash_erase_req |=> !flash_wr)
		else $error("flash write while disabled");
	blocked_quiet_a: assert property (flash_blocked |-> !flash_wr && !flash_erase)
		else $error("blocked access reached flash");
	code_read_a: assert property (code_rd && !xmove_wr && !flash_erase_req
		|=> code_rd_en && !flash_wr && !flash_erase)
		else $error("code read misrouted");
	direct_sfr_a: assert property (!data_indirect && data_addr[7] |=>
		data_region == mcreg_pkg::MCREG_SPECIAL)
		else $error("direct upper access not special");
	upper_ram_a: assert property (data_indirect && data_addr[7] |=>
		data_region == mcreg_pkg::MCREG_UPPER_RAM)
		else $error("indirect upper access not ram");
	bit_area_a: assert property (data_addr inside {[8'h20:8'h2F]} |=>
		data_region == mcreg_pkg::MCREG_BIT_AREA)
		else $error("bit area decode wrong");
	general_ram_a: assert property (data_addr inside {[8'h30:8'h7F]} |=>
		data_region == mcreg_pkg::MCREG_GENERAL)
		else $error("general area decode wrong");
endmodule : mcreg_monitor

bind mcreg_memory_control mcreg_monitor i_mon (.clk, .rst, .sfr_wr, .sfr_rd,
	.sfr_addr, .sfr_wdata, .sfr_rdata, .sfr_hit, .data_addr, .data_indirect,
	.data_region, .xmove_wr, .code_rd, .flash_erase_req, .flash_wr,
	.flash_erase, .flash_blocked, .code_rd_en, .stop_enable,
	.program_write_enable);

//--- testbench/memory_control_registers_test.sv
`timescale 1ns/1ps
module memory_control_registers_test;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic sfr_wr, sfr_rd, sfr_hit, data_indirect, ptr_instr, ptr_step;
	logic xmove_wr, code_rd, flash_erase_req, flash_wr, flash_erase;
	logic flash_blocked, code_rd_en, idle_mode, stop_enable;
	logic stop_wake_reset, baud_doubler, program_write_enable;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, data_addr, acc_value;
	logic [7:0] flash_wdata;
	logic [15:0] active_pointer, flash_erase_addr, flash_addr;
	logic [2:0] data_region;
	logic [1:0] data_bank;
	logic [6:0] data_bit_index;
	logic [7:0] regs [7] = '{8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h87, 8'hED};
	int errors = 0;
	int check_count = 0;
	int cyc = 0;
	always #2.5 clk = ~clk;
	mcreg_memory_control i_dut (.clk, .rst, .sfr_wr, .sfr_rd, .sfr_addr,
		.sfr_wdata, .sfr_rdata, .sfr_hit, .data_addr, .data_indirect,
		.data_region, .data_bank, .data_bit_index, .ptr_instr, .ptr_step,
		.active_pointer, .xmove_wr, .code_rd, .flash_erase_req,
		.flash_erase_addr, .acc_value, .flash_wr, .flash_addr, .flash_wdata,
		.flash_erase, .flash_blocked, .code_rd_en, .idle_mode, .stop_enable,
		.stop_wake_reset, .baud_doubler, .program_write_enable);
	mcreg_core_model i_core (.clk, .sfr_wr, .sfr_rd, .sfr_addr, .sfr_wdata,
		.sfr_rdata, .sfr_hit);
	task automatic chk(string n, logic [15:0] e, logic [15:0] g);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic h;
		i_core.rd(a, d, h);
		chk("rdata", {e, 8'h01}, {d, 7'h00, h});
	endtask : rd_chk
	task automatic pulse(input logic [2:0] kind);
		@(posedge clk);
		#1;
		{ptr_instr, xmove_wr, code_rd} = kind;
		@(posedge clk);
		#1;
		{ptr_instr, xmove_wr, code_rd} = 3'h0;
	endtask : pulse
	task automatic t_regs;
		logic [7:0] d;
		logic h;
		foreach (regs[i]) rd_chk(regs[i], 8'h00);
		i_core.rd(8'h88, d, h);
		chk("hole", 16'h0000, {d, 7'h00, h});
		foreach (regs[i]) i_core.wr(regs[i], 8'hDE);
		foreach (regs[i]) rd_chk(regs[i], 8'hDE);
		chk("power", 5'h17, {baud_doubler, idle_mode, program_write_enable,
			stop_wake_reset, stop_enable});
		i_core.wr(8'h87, 8'h20);
		chk("power", 5'h08, {baud_doubler, idle_mode, program_write_enable,
			stop_wake_reset, stop_enable});
	endtask : t_regs
	task automatic t_ptr;
		i_core.wr(8'h82, 8'hFF);
		i_core.wr(8'h83, 8'h00);
		i_core.wr(8'h84, 8'h00);
		i_core.wr(8'h85, 8'h00);
		i_core.wr(8'h86, 8'hA0);
		ptr_step = 1'b1;
		@(posedge clk);
		#1;
		ptr_instr = 1'b1;
		@(posedge clk);
		#1;
		chk("ptr", 16'h0100, active_pointer);
		@(posedge clk);
		#1;
		ptr_instr = 1'b0;
		chk("ptr", 16'hFFFF, active_pointer);
		rd_chk(8'h86, 8'hA0);
		rd_chk(8'h83, 8'h01);
		i_core.wr(8'h86, 8'h41);
		pulse(3'h4);
		chk("ptr", 16'h0000, active_pointer);
		rd_chk(8'h86, 8'h41);
		i_core.wr(8'h86, 8'h00);
	endtask : t_ptr
	task automatic try(input logic [7:0] lvl, input logic [15:0] a,
		input logic er, input logic [2:0] e);
		i_core.wr(8'hED, lvl);
		i_core.wr(8'h82, a[7:0]);
		i_core.wr(8'h83, a[15:8]);
		// Erase and write requests stand for exactly one edge
		@(posedge clk);
		#1;
		flash_erase_addr = a;
		{flash_erase_req, xmove_wr} = {er, !er};
		@(posedge clk);
		#1;
		{flash_erase_req, xmove_wr} = 2'h0;
		flash_erase_addr = ~a;
		chk("flash", e, {flash_wr, flash_erase, flash_blocked});
		if (e[2] | e[1])
			chk("faddr", a, flash_addr);
		if (e[2])
			chk("fdata", acc_value, flash_wdata);
	endtask : try
	task automatic t_flash;
		i_core.wr(8'h87, 8'h10);
		try(8'h02, 16'h07FF, 1'b0, 3'h1);
		try(8'h02, 16'h0800, 1'b0, 3'h4);
		try(8'h1F, 16'h7BFF, 1'b1, 3'h1);
		try(8'h1F, 16'h7C00, 1'b1, 3'h2);
		try(8'h20, 16'h7FFE, 1'b0, 3'h1);
		try(8'h3F, 16'h7FFF, 1'b1, 3'h2);
		try(8'h40, 16'h0000, 1'b0, 3'h4);
		i_core.wr(8'h87, 8'h00);
		try(8'h00, 16'h1234, 1'b0, 3'h0);
		pulse(3'h1);
		chk("code", 2'h2, {code_rd_en, flash_wr});
	endtask : t_flash
	task automatic t_decode;
		logic [7:0] a [6] = '{8'h1F, 8'h20, 8'h2F, 8'h7F, 8'h80, 8'hFF};
		// Region codes: bank, bit area, general, upper ram, special
		logic [2:0] r [6] = '{3'h0, 3'h1, 3'h1, 3'h2, 3'h3, 3'h4};
		foreach (a[i]) begin
			data_addr = a[i];
			data_indirect = (i == 4);
			@(posedge clk);
			#1;
			chk("region", r[i], data_region);
			if (i == 0)
				chk("bank", 2'h3, data_bank);
			if (i == 2)
				chk("bit", 7'h78, data_bit_index);
		end
	endtask : t_decode
	task automatic results;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : results
	// Whole run needs well under a thousand cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			errors++;
			$display("[FAIL] timeout expected done seen hang");
			results();
		end
	end
	initial begin
		{ptr_instr, ptr_step, xmove_wr, code_rd, flash_erase_req} = 5'h00;
		data_addr = 8'h00;
		data_indirect = 1'b0;
		acc_value = 8'h5A;
		flash_erase_addr = 16'h0000;
		repeat (10) @(posedge clk);
		#1;
		rst = 1'b0;
		t_regs();
		t_ptr();
		t_flash();
		t_decode();
		results();
	end
endmodule : memory_control_registers_test

//--- verilog/mcreg_memory_control.sv
`timescale 1ns/1ps
module mcreg_memory_control #(
	parameter int FLASH_KB = 32
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Special register bus from the core
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	output logic sfr_hit,
	// Data memory address decode
	input wire logic [7:0] data_addr,
	input wire logic data_indirect,
	output logic [2:0] data_region,
	output logic [1:0] data_bank,
	output logic [6:0] data_bit_index,
	// Pointer instructions
	input wire logic ptr_instr,
	input wire logic ptr_step,
	output logic [15:0] active_pointer,
	// Program memory access
	input wire logic xmove_wr,
	input wire logic code_rd,
	input wire logic flash_erase_req,
	input wire logic [15:0] flash_erase_addr,
	input wire logic [7:0] acc_value,
	output logic flash_wr,
	output logic [15:0] flash_addr,
	output logic [7:0] flash_wdata,
	output logic flash_erase,
	output logic flash_blocked,
	output logic code_rd_en,
	// Power controls
	output logic idle_mode,
	output logic stop_enable,
	output logic stop_wake_reset,
	output logic baud_doubler,
	output logic program_write_enable
);

	localparam logic [5:0] LEVEL_MASK = (FLASH_KB == 32) ? 6'h3F :
		(FLASH_KB == 16) ? 6'h1F : 6'h0F;

	// Only the three flash sizes have a defined level width
	if (FLASH_KB != 32 && FLASH_KB != 16 &&
		FLASH_KB != 8) begin : g_bad_size
		$error("FLASH_KB must be 8, 16 or 32");
	end

	// Decode compares only upper bounds, so the regions must abut
	localparam bit MAP_ABUTS =
		mcreg_pkg::BIT_AREA_BASE == mcreg_pkg::BANK_END + 8'h01 &&
		mcreg_pkg::GENERAL_BASE == mcreg_pkg::BIT_AREA_END + 8'h01 &&
		mcreg_pkg::UPPER_BASE == mcreg_pkg::GENERAL_END + 8'h01;
	if (!MAP_ABUTS) begin : g_bad_map
		$error("data memory regions must abut");
	end

	// Partial levels must stay below the full-protection limit
	localparam logic [31:0] TOP_PARTIAL =
		32'(mcreg_pkg::FULL_LEVEL - 6'h01) * 32'(mcreg_pkg::PAGE_SIZE);
	if (TOP_PARTIAL >= 32'(mcreg_pkg::FULL_LIMIT)) begin : g_bad_limit
		$error("partial protection reaches the full limit");
	end

	// Register state
	logic [7:0] pointer0_low, pointer0_high;
	logic [7:0] pointer1_low, pointer1_high;
	logic [7:0] pointer_select_ctrl, power_config, write_protect_level;
	logic [7:0] next_pointer0_low, next_pointer0_high;
	logic [7:0] next_pointer1_low, next_pointer1_high;
	logic [7:0] next_pointer_select_ctrl, next_power_config;
	logic [7:0] next_write_protect_level;

	logic [5:0] level;
	logic [15:0] protect_limit;
	logic [15:0] ptr0, ptr1, ptr_sel_val, ptr0_stepped, ptr1_stepped;
	logic sel;

	assign level = write_protect_level[5:0] & LEVEL_MASK;
	assign sel = pointer_select_ctrl[mcreg_pkg::SEL_BIT];
	assign ptr0 = {pointer0_high, pointer0_low};
	assign ptr1 = {pointer1_high, pointer1_low};
	assign ptr_sel_val = sel ? ptr1 : ptr0;

	// Step direction: bit 6 for pointer zero, bit 7 for pointer one
	logic [15:0] ptr_now [2];
	logic [15:0] ptr_step_val [2];
	assign ptr_now[0] = ptr0;
	assign ptr_now[1] = ptr1;
	for (genvar p = 0; p < 2; p++) begin : g_step
		localparam int DIR_BIT = (p == 0) ? mcreg_pkg::STEP0_BIT :
			mcreg_pkg::STEP1_BIT;
		// A set direction bit counts down; both wrap at 16 bits
		assign ptr_step_val[p] = pointer_select_ctrl[DIR_BIT] ?
			ptr_now[p] - 16'h0001 : ptr_now[p] + 16'h0001;
	end
	assign ptr0_stepped = ptr_step_val[0];
	assign ptr1_stepped = ptr_step_val[1];

	// Level counts whole 1K pages upward from address zero
	always_comb begin
		if (level == 6'h00)
			protect_limit = 16'h0000;
		else if (level >= mcreg_pkg::FULL_LEVEL)
			protect_limit = mcreg_pkg::FULL_LIMIT;
		else
			protect_limit = 16'(level) * mcreg_pkg::PAGE_SIZE;
	end

	// Register writes, pointer steps and toggles
	always_comb begin
		next_pointer0_low = pointer0_low;
		next_pointer0_high = pointer0_high;
		next_pointer1_low = pointer1_low;
		next_pointer1_high = pointer1_high;
		next_pointer_select_ctrl = pointer_select_ctrl;
		next_power_config = power_config;
		next_write_protect_level = write_protect_level;
		// Stepping needs both the instruction and its step flag
		if (ptr_instr && ptr_step) begin
			if (!sel)
				{next_pointer0_high, next_pointer0_low} = ptr0_stepped;
			else
				{next_pointer1_high, next_pointer1_low} = ptr1_stepped;
		end
		// Toggle lands in the register now, so the next instruction sees it
		if (ptr_instr && pointer_select_ctrl[mcreg_pkg::TOGGLE_BIT])
			next_pointer_select_ctrl[mcreg_pkg::SEL_BIT] = !sel;
		// A software write in the same cycle wins over hardware updates
		if (sfr_wr) begin
			unique case (sfr_addr)
				mcreg_pkg::ADDR_POINTER0_LOW: next_pointer0_low = sfr_wdata;
				mcreg_pkg::ADDR_POINTER0_HIGH: next_pointer0_high = sfr_wdata;
				mcreg_pkg::ADDR_POINTER1_LOW: next_pointer1_low = sfr_wdata;
				mcreg_pkg::ADDR_POINTER1_HIGH: next_pointer1_high = sfr_wdata;
				mcreg_pkg::ADDR_POINTER_SELECT_CTRL:
					next_pointer_select_ctrl = sfr_wdata;
				mcreg_pkg::ADDR_POWER_CONFIG: next_power_config = sfr_wdata;
				mcreg_pkg::ADDR_WRITE_PROTECT_LEVEL:
					next_write_protect_level = sfr_wdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pointer0_low <= mcreg_pkg::RESET_BYTE;
			pointer0_high <= mcreg_pkg::RESET_BYTE;
			pointer1_low <= mcreg_pkg::RESET_BYTE;
			pointer1_high <= mcreg_pkg::RESET_BYTE;
			pointer_select_ctrl <= mcreg_pkg::RESET_BYTE;
			power_config <= mcreg_pkg::RESET_BYTE;
			write_protect_level <= mcreg_pkg::RESET_BYTE;
		end else begin
			pointer0_low <= next_pointer0_low;
			pointer0_high <= next_pointer0_high;
			pointer1_low <= next_pointer1_low;
			pointer1_high <= next_pointer1_high;
			pointer_select_ctrl <= next_pointer_select_ctrl;
			power_config <= next_power_config;
			write_protect_level <= next_write_protect_level;
		end
	end

	// Registered outputs
	logic [7:0] next_sfr_rdata;
	logic next_sfr_hit;
	logic [2:0] next_data_region;
	logic [1:0] next_data_bank;
	logic [6:0] next_data_bit_index;
	logic next_flash_wr, next_flash_erase, next_flash_blocked;
	logic [15:0] next_flash_addr;
	logic [7:0] next_flash_wdata;
	logic [15:0] wr_addr;
	logic wr_req;
	logic in_protected;

	always_comb begin
		next_sfr_hit = 1'b1;
		next_sfr_rdata = 8'h00;
		unique case (sfr_addr)
			mcreg_pkg::ADDR_POINTER0_LOW: next_sfr_rdata = pointer0_low;
			mcreg_pkg::ADDR_POINTER0_HIGH: next_sfr_rdata = pointer0_high;
			mcreg_pkg::ADDR_POINTER1_LOW: next_sfr_rdata = pointer1_low;
			mcreg_pkg::ADDR_POINTER1_HIGH: next_sfr_rdata = pointer1_high;
			mcreg_pkg::ADDR_POINTER_SELECT_CTRL:
				next_sfr_rdata = pointer_select_ctrl;
			mcreg_pkg::ADDR_POWER_CONFIG: next_sfr_rdata = power_config;
			mcreg_pkg::ADDR_WRITE_PROTECT_LEVEL:
				next_sfr_rdata = write_protect_level;
			default: next_sfr_hit = 1'b0;
		endcase
		// Reads back zero unless strobed, so no stale byte looks valid
		if (!sfr_rd) begin
			next_sfr_rdata = 8'h00;
			next_sfr_hit = 1'b0;
		end
	end

	always_comb begin
		next_data_bank = data_addr[4:3];
		// Number of bit 0 of the addressed byte inside the bit area
		next_data_bit_index = {data_addr[3:0], 3'b000};
		if (data_addr <= mcreg_pkg::BANK_END)
			next_data_region = 3'(mcreg_pkg::MCREG_BANK);
		else if (data_addr <= mcreg_pkg::BIT_AREA_END)
			next_data_region = 3'(mcreg_pkg::MCREG_BIT_AREA);
		else if (data_addr <= mcreg_pkg::GENERAL_END)
			next_data_region = 3'(mcreg_pkg::MCREG_GENERAL);
		else if (data_indirect)
			next_data_region = 3'(mcreg_pkg::MCREG_UPPER_RAM);
		else
			next_data_region = 3'(mcreg_pkg::MCREG_SPECIAL);
	end

	assign wr_addr = flash_erase_req ? flash_erase_addr : ptr_sel_val;
	// Writes need the enable; erases are assumed already gated upstream
	assign wr_req = (xmove_wr && power_config[mcreg_pkg::PWE_BIT]) ||
		flash_erase_req;
	// Strict compare: at full level the topmost byte stays writable
	assign in_protected = wr_addr < protect_limit;

	always_comb begin
		next_flash_wr = 1'b0;
		next_flash_erase = 1'b0;
		next_flash_blocked = 1'b0;
		next_flash_addr = wr_addr;
		next_flash_wdata = acc_value;
		if (wr_req) begin
			if (in_protected)
				next_flash_blocked = 1'b1;
			// Erase outranks a same-cycle write and brings its own address
			else if (flash_erase_req)
				next_flash_erase = 1'b1;
			else
				next_flash_wr = 1'b1;
		end
	end

	// Next values of the outputs not produced above
	logic [15:0] next_active_pointer;
	logic next_code_rd_en;
	logic next_idle_mode, next_stop_enable, next_stop_wake_reset;
	logic next_baud_doubler, next_program_write_enable;

	// Old select for this cycle; a toggle shows from the next cycle on
	always_comb begin
		if (sel)
			next_active_pointer = {next_pointer1_high, next_pointer1_low};
		else
			next_active_pointer = {next_pointer0_high, next_pointer0_low};
	end

	// Code reads never depend on the write enable
	always_comb begin
		next_code_rd_en = code_rd;
	end

	// Levels follow the value being loaded, so they move at the write edge
	always_comb begin
		next_idle_mode = next_power_config[mcreg_pkg::IDLE_BIT];
		next_stop_enable = next_power_config[mcreg_pkg::STOP_BIT];
		next_stop_wake_reset =
			next_power_config[mcreg_pkg::STOP_RESET_BIT];
		next_baud_doubler = next_power_config[mcreg_pkg::BAUD_BIT];
		next_program_write_enable =
			next_power_config[mcreg_pkg::PWE_BIT];
	end

	// Register bus answer
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sfr_rdata <= 8'h00;
			sfr_hit <= 1'b0;
		end else begin
			sfr_rdata <= next_sfr_rdata;
			sfr_hit <= next_sfr_hit;
		end
	end

	// Data memory decode
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			data_region <= 3'h0;
			data_bank <= 2'h0;
			data_bit_index <= 7'h00;
		end else begin
			data_region <= next_data_region;
			data_bank <= next_data_bank;
			data_bit_index <= next_data_bit_index;
		end
	end

	// Active pointer view
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			active_pointer <= 16'h0000;
		end else begin
			active_pointer <= next_active_pointer;
		end
	end

	// Flash requests
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flash_wr <= 1'b0;
			flash_erase <= 1'b0;
			flash_blocked <= 1'b0;
			flash_addr <= 16'h0000;
			flash_wdata <= 8'h00;
		end else begin
			flash_wr <= next_flash_wr;
			flash_erase <= next_flash_erase;
			flash_blocked <= next_flash_blocked;
			flash_addr <= next_flash_addr;
			flash_wdata <= next_flash_wdata;
		end
	end

	// Code read
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			code_rd_en <= 1'b0;
		end else begin
			code_rd_en <= next_code_rd_en;
		end
	end

	// Power levels
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			idle_mode <= 1'b0;
			stop_enable <= 1'b0;
			stop_wake_reset <= 1'b0;
			baud_doubler <= 1'b0;
			program_write_enable <= 1'b0;
		end else begin
			idle_mode <= next_idle_mode;
			stop_enable <= next_stop_enable;
			stop_wake_reset <= next_stop_wake_reset;
			baud_doubler <= next_baud_doubler;
			program_write_enable <= next_program_write_enable;
		end
	end

endmodule : mcreg_memory_control

//--- verilog/mcreg_pkg.sv
package mcreg_pkg;
	// Register addresses on the special register bus
	localparam logic [7:0] ADDR_POINTER0_LOW = 8'h82;
	localparam logic [7:0] ADDR_POINTER0_HIGH = 8'h83;
	localparam logic [7:0] ADDR_POINTER1_LOW = 8'h84;
	localparam logic [7:0] ADDR_POINTER1_HIGH = 8'h85;
	localparam logic [7:0] ADDR_POINTER_SELECT_CTRL = 8'h86;
	localparam logic [7:0] ADDR_POWER_CONFIG = 8'h87;
	localparam logic [7:0] ADDR_WRITE_PROTECT_LEVEL = 8'hED;
	// Reset values
	localparam logic [7:0] RESET_BYTE = 8'h00;
	// Field positions
	localparam int SEL_BIT = 0;
	localparam int TOGGLE_BIT = 5;
	localparam int STEP0_BIT = 6;
	localparam int STEP1_BIT = 7;
	localparam int STOP_BIT = 1;
	localparam int STOP_RESET_BIT = 3;
	localparam int PWE_BIT = 4;
	localparam int IDLE_BIT = 5;
	localparam int BAUD_BIT = 7;
	// Data memory map
	localparam logic [7:0] BANK_END = 8'h1F;
	localparam logic [7:0] BIT_AREA_BASE = 8'h20;
	localparam logic [7:0] BIT_AREA_END = 8'h2F;
	localparam logic [7:0] GENERAL_BASE = 8'h30;
	localparam logic [7:0] GENERAL_END = 8'h7F;
	localparam logic [7:0] UPPER_BASE = 8'h80;
	// Flash protection
	localparam logic [15:0] PAGE_SIZE = 16'h0400;
	localparam logic [15:0] FULL_LIMIT = 16'h7FFF;
	localparam logic [5:0] FULL_LEVEL = 6'h20;
	// Data memory region codes
	typedef enum logic [2:0] {
		MCREG_BANK,
		MCREG_BIT_AREA,
		MCREG_GENERAL,
		MCREG_UPPER_RAM,
		MCREG_SPECIAL
	} mcreg_region_e;
endpackage : mcreg_pkg
